// *** hw/odu_frame_rx.sv ***
// Serial frame receiver sampling the link clock with the system clock.
`timescale 1ns/1ns
module odu_frame_rx
    import odu_pkg::*;
(
    input  wire logic            clk_in,
    input  wire logic            rst_n_in,
    input  wire logic            sclk_in,
    input  wire logic            sdi_in,
    input  wire logic            frame_sel_n_in,
    output odu_frame_s           frame_out,
    output logic                 frame_valid_out
);

    logic                   sclk_prev_q;
    logic                   fs_prev_q;
    logic [FRAME_BITS-1:0]  shift_q;
    logic [COUNT_WIDTH-1:0] count_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_prev_q <= 1'b0;
            fs_prev_q   <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_in;
            fs_prev_q   <= frame_sel_n_in;
        end
    end

    // Data is shifted on each falling link clock edge while the frame is selected.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_q <= '0;
            count_q <= '0;
        end else if (frame_sel_n_in) begin
            count_q <= '0;
        end else if (sclk_prev_q && !sclk_in) begin
            shift_q <= {shift_q[FRAME_BITS-2:0], sdi_in};
            if (count_q != COUNT_WIDTH'(FRAME_BITS)) begin
                count_q <= count_q + 5'h01;
            end
        end
    end

    // The frame is latched on the rising edge of frame select.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            frame_out       <= '0;
            frame_valid_out <= 1'b0;
        end else begin
            frame_valid_out <= 1'b0;
            if (!fs_prev_q && frame_sel_n_in && count_q == COUNT_WIDTH'(FRAME_BITS)) begin
                frame_out       <= shift_q;
                frame_valid_out <= 1'b1;
            end
        end
    end

endmodule

// *** hw/odu_pkg.sv ***
// Package with constants and types of the octal converter update and reset control.
// Functional notes
// - With strobe high, write frames wait; strobe falling edge later updates unmasked outputs.
// - Command 0101 loads the eight-bit channel load mask from data bits 7..0.
// - Mask bits reset to zero; zero means the strobe pin governs that channel.
// - A masked channel ignores strobe transitions; with the strobe low it still follows 0001 writes.
// - Command 0001 writes input register; converter register follows only when strobe is low.
// - Command 0010 copies selected input registers to converter registers; inputs unchanged.
// - Command 0011 writes input and converter register of the addressed channel.
// - Each strobe falling edge copies input to converter registers on unmasked channels.
// - With the strobe held low, mask bits are disregarded.
// - Hardware reset low clears outputs to zero or midscale per the level select pin.
// - After hardware reset release, outputs hold the cleared value until a new write.
// - While hardware reset is low, every channel register update is blocked; mask and setup frames still load.
// - Command 0110 is a software reset back to the power-on code.
// - During power-on reset, strobe and hardware reset pin activity is ignored.
// - Power-up code is zero scale for select low, midscale for select high.
// - Variant without level select pin powers all outputs up to zero.
// - Command 0111 loads reference and gain setup; bits 19..3 ignored, bit 1 zero.
// - Setup bit 2 selects gain: zero gives one, one gives two.
// - Setup bit 0 zero keeps reference on; one switches it off.
// - Strobe low during a 0001 frame updates both registers at frame select rise.
package odu_pkg;

    localparam int NUM_CHANNELS = 8;
    localparam int CODE_WIDTH   = 16;
    localparam int FRAME_BITS   = 24;
    localparam int COUNT_WIDTH  = 5;

    localparam logic [3:0] CMD_WRITE_INPUT  = 4'h1;
    localparam logic [3:0] CMD_UPDATE_DAC   = 4'h2;
    localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
    localparam logic [3:0] CMD_LOAD_MASK    = 4'h5;
    localparam logic [3:0] CMD_SOFT_RESET   = 4'h6;
    localparam logic [3:0] CMD_SETUP        = 4'h7;

    localparam int SETUP_GAIN_BIT = 2;
    localparam int SETUP_RSVD_BIT = 1;
    localparam int SETUP_REF_BIT  = 0;
    localparam int SETUP_WIDTH    = 3;

    localparam logic [7:0]            MASK_RESET  = 8'h00;
    localparam logic [SETUP_WIDTH-1:0] SETUP_RESET = 3'h0;
    localparam logic [CODE_WIDTH-1:0] CODE_ZERO   = 16'h0000;
    localparam logic [CODE_WIDTH-1:0] CODE_MID    = 16'h8000;

    localparam int SYNC_WIDTH = 7;
    localparam int POR_SETTLE = 2;

    typedef struct packed {
        logic [3:0]            cmd;
        logic [3:0]            addr;
        logic [CODE_WIDTH-1:0] data;
    } odu_frame_s;

    typedef struct packed {
        logic sclk;
        logic sdi;
        logic frame_sel_n;
        logic load_strobe_n;
        logic hw_reset_n;
        logic power_up_level_select;
        logic has_level_select;
    } odu_pins_s;

endpackage

// *** hw/odu_sync.sv ***
// Two-flop synchroniser for the pin inputs.
`timescale 1ns/1ns
module odu_sync
    import odu_pkg::*;
(
    input  wire logic            clk_in,
    input  wire logic            rst_n_in,
    input  wire odu_pins_s       pins_in,
    output odu_pins_s            pins_out
);

    odu_pins_s stage_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage_q  <= '0;
            pins_out <= '0;
        end else begin
            stage_q  <= pins_in;
            pins_out <= stage_q;
        end
    end

endmodule

// *** hw/odu_top.sv ***
// Update, mask, reset and setup control of an eight-channel converter.
`timescale 1ns/1ns
module odu_top
    import odu_pkg::*;
(
    input  wire logic                                  mclk_in,
    input  wire logic                                  resetn_in,
    input  wire logic                                  sclk_in,
    input  wire logic                                  sdi_in,
    input  wire logic                                  frame_sel_n_in,
    input  wire logic                                  load_strobe_n_in,
    input  wire logic                                  hw_reset_n_in,
    input  wire logic                                  power_up_level_select_in,
    input  wire logic                                  has_level_select_in,
    output logic [NUM_CHANNELS-1:0][CODE_WIDTH-1:0]    dac_code_out,
    output logic [NUM_CHANNELS-1:0][CODE_WIDTH-1:0]    input_code_out,
    output logic [NUM_CHANNELS-1:0]                    load_mask_out,
    output logic                                       gain_two_out,
    output logic                                       reference_off_out,
    output logic                                       por_busy_out
);

    logic [1:0]                                 rst_ff_q;
    logic                                       rst_n;
    odu_pins_s                                  pins_raw;
    odu_pins_s                                  pins_s;
    odu_frame_s                                 frame;
    logic                                       frame_valid;
    logic                                       strobe_prev_q;
    logic                                       strobe_fall;
    logic                                       por_done_q;
    logic [1:0]                                 por_cnt_q;
    logic                                       level_q;
    logic                                       has_pin_q;
    logic                                       soft_reset;
    logic [NUM_CHANNELS-1:0][CODE_WIDTH-1:0]    input_q;
    logic [NUM_CHANNELS-1:0][CODE_WIDTH-1:0]    dac_q;
    logic [NUM_CHANNELS-1:0]                    mask_q;
    logic [SETUP_WIDTH-1:0]                     setup_q;

    // Returns the clear code for a level select setting and package variant.
    function automatic logic [CODE_WIDTH-1:0] clear_code(input logic level_high, input logic has_pin);
        if (has_pin && level_high) begin
            clear_code = CODE_MID;
        end else begin
            clear_code = CODE_ZERO;
        end
    endfunction

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_ff_q <= 2'h0;
        end else begin
            rst_ff_q <= {rst_ff_q[0], 1'b1};
        end
    end

    assign rst_n = rst_ff_q[1];

    assign pins_raw = '{sclk:                  sclk_in,
                        sdi:                   sdi_in,
                        frame_sel_n:           frame_sel_n_in,
                        load_strobe_n:         load_strobe_n_in,
                        hw_reset_n:            hw_reset_n_in,
                        power_up_level_select: power_up_level_select_in,
                        has_level_select:      has_level_select_in};

    odu_sync i_odu_sync (
        .clk_in   (mclk_in),
        .rst_n_in (rst_n),
        .pins_in  (pins_raw),
        .pins_out (pins_s)
    );

    odu_frame_rx i_odu_frame_rx (
        .clk_in          (mclk_in),
        .rst_n_in        (rst_n),
        .sclk_in         (pins_s.sclk),
        .sdi_in          (pins_s.sdi),
        .frame_sel_n_in  (pins_s.frame_sel_n),
        .frame_out       (frame),
        .frame_valid_out (frame_valid)
    );

    // The power-on interval waits until the synchronisers hold real pin values; straps are caught then.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            por_done_q <= 1'b0;
            por_cnt_q  <= 2'h0;
            level_q    <= 1'b0;
            has_pin_q  <= 1'b0;
        end else if (!por_done_q) begin
            if (por_cnt_q == 2'(POR_SETTLE)) begin
                por_done_q <= 1'b1;
                level_q    <= pins_s.power_up_level_select;
                has_pin_q  <= pins_s.has_level_select;
            end else begin
                por_cnt_q <= por_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            strobe_prev_q <= 1'b1;
        end else if (!por_done_q) begin
            strobe_prev_q <= 1'b1;
        end else begin
            strobe_prev_q <= pins_s.load_strobe_n;
        end
    end

    assign strobe_fall = por_done_q && strobe_prev_q && !pins_s.load_strobe_n;
    assign soft_reset  = frame_valid && frame.cmd == CMD_SOFT_RESET;

    // Channel input and converter registers.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            input_q <= '0;
            dac_q   <= '0;
        end else begin
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                if (!por_done_q) begin
                    input_q[i] <= clear_code(pins_s.power_up_level_select, pins_s.has_level_select);
                    dac_q[i]   <= clear_code(pins_s.power_up_level_select, pins_s.has_level_select);
                end else if (!pins_s.hw_reset_n) begin
                    input_q[i] <= clear_code(pins_s.power_up_level_select, has_pin_q);
                    dac_q[i]   <= clear_code(pins_s.power_up_level_select, has_pin_q);
                end else if (soft_reset) begin
                    input_q[i] <= clear_code(level_q, has_pin_q);
                    dac_q[i]   <= clear_code(level_q, has_pin_q);
                end else begin
                    // Registers hold otherwise, so a cleared value stays until written.
                    if (frame_valid && frame.addr == 4'(i) &&
                        (frame.cmd == CMD_WRITE_INPUT || frame.cmd == CMD_WRITE_UPDATE)) begin
                        input_q[i] <= frame.data;
                    end
                    if (frame_valid && frame.addr == 4'(i) && frame.cmd == CMD_WRITE_UPDATE) begin
                        dac_q[i] <= frame.data;
                    end else if (frame_valid && frame.addr == 4'(i) && frame.cmd == CMD_WRITE_INPUT &&
                                 !pins_s.load_strobe_n) begin
                        dac_q[i] <= frame.data;
                    end else if (frame_valid && frame.cmd == CMD_UPDATE_DAC && frame.data[i]) begin
                        dac_q[i] <= input_q[i];
                    end else if (strobe_fall && !mask_q[i]) begin
                        dac_q[i] <= input_q[i];
                    end
                end
            end
        end
    end

    // Load mask and reference/gain setup.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            mask_q  <= MASK_RESET;
            setup_q <= SETUP_RESET;
        end else if (!por_done_q || soft_reset) begin
            mask_q  <= MASK_RESET;
            setup_q <= SETUP_RESET;
        end else if (frame_valid && frame.cmd == CMD_LOAD_MASK) begin
            mask_q <= frame.data[NUM_CHANNELS-1:0];
        end else if (frame_valid && frame.cmd == CMD_SETUP) begin
            setup_q <= frame.data[SETUP_WIDTH-1:0];
        end
    end

    assign dac_code_out      = dac_q;
    assign input_code_out    = input_q;
    assign load_mask_out     = mask_q;
    assign gain_two_out      = setup_q[SETUP_GAIN_BIT];
    assign reference_off_out = setup_q[SETUP_REF_BIT];
    assign por_busy_out      = !por_done_q;

endmodule

// *** test/odu_host_model.sv ***
// Host serial controller model that sends command frames to the converter control.
`timescale 1ns/1ns
module odu_host_model
    import odu_pkg::*;
(
    input  wire logic clk_in,
    output logic      sclk_out,
    output logic      sdi_out,
    output logic      frame_sel_n_out
);
    initial begin
        sclk_out = 1'b1;
        sdi_out = 1'b0;
        frame_sel_n_out = 1'b1;
    end
    // Sends one frame MSB first; data moves while the clock is high, 80 ns period.
    task automatic send(input odu_frame_s frame);
        @(posedge clk_in);
        frame_sel_n_out <= 1'b0;
        for (int i = FRAME_BITS - 1; i >= 0; i--) begin
            sdi_out <= frame[i];
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'b0;
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'b1;
        end
        repeat (4) @(posedge clk_in);
        frame_sel_n_out <= 1'b1;
        sdi_out <= ~frame[0];
        repeat (4) @(posedge clk_in);
    endtask
endmodule

// *** test/odu_top_properties.sv ***
// Checker of reset, clear and hold behaviour at the converter control ports.
`timescale 1ns/1ns
module odu_top_properties
    import odu_pkg::*;
(
    input wire logic                                mclk_in,
    input wire logic                                resetn_in,
    input wire logic                                frame_sel_n_in,
    input wire logic                                load_strobe_n_in,
    input wire logic                                hw_reset_n_in,
    input wire logic                                power_up_level_select_in,
    input wire logic                                has_level_select_in,
    input wire logic [NUM_CHANNELS-1:0][CODE_WIDTH-1:0] dac_code_out,
    input wire logic [NUM_CHANNELS-1:0][CODE_WIDTH-1:0] input_code_out,
    input wire logic [NUM_CHANNELS-1:0]             load_mask_out,
    input wire logic                                gain_two_out,
    input wire logic                                reference_off_out,
    input wire logic                                por_busy_out
);
    logic [NUM_CHANNELS-1:0][CODE_WIDTH-1:0] clr_all;
    logic [3:0]                              quiet_q;
    logic                                    fs_q;
    logic                                    ld_q;
    assign clr_all = {NUM_CHANNELS{(has_level_select_in && power_up_level_select_in) ? CODE_MID : CODE_ZERO}};
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fs_q <= 1'b1;
            ld_q <= 1'b1;
        end else begin
            fs_q <= frame_sel_n_in;
            ld_q <= load_strobe_n_in;
        end
    end
    // Counts cycles since the last event that may legally change a register.
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            quiet_q <= 4'h0;
        end else if ((frame_sel_n_in && !fs_q) || (ld_q && !load_strobe_n_in) || !hw_reset_n_in || por_busy_out) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hf) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!resetn_in);
    chk_por_regs_zero: assert property (por_busy_out |-> !load_mask_out && !gain_two_out && !reference_off_out)
        else $error("mask or setup not clear in power-on");
    chk_por_dac_zero: assert property (por_busy_out |-> !dac_code_out && !input_code_out)
        else $error("codes not clear in power-on");
    chk_por_busy_end: assert property ($rose(resetn_in) |-> ##[1:10] !por_busy_out)
        else $error("power-on interval too long");
    chk_por_clear_code: assert property ($fell(por_busy_out) |=> dac_code_out == clr_all)
        else $error("wrong power-on code");
    chk_hw_dac_clear: assert property ((!hw_reset_n_in && !por_busy_out)[*5] |-> dac_code_out == clr_all)
        else $error("outputs not cleared by reset pin");
    chk_hw_input_block: assert property ((!hw_reset_n_in && !por_busy_out)[*5] |-> input_code_out == clr_all)
        else $error("input written under reset pin");
    chk_quiet_dac_hold: assert property (quiet_q >= 4'd8 |-> $stable(dac_code_out) && $stable(input_code_out))
        else $error("codes changed without cause");
    chk_quiet_setup: assert property (quiet_q >= 4'd8 |-> $stable({load_mask_out, gain_two_out, reference_off_out}))
        else $error("mask or setup changed without cause");
    cov_strobe_masked: cover property ($fell(load_strobe_n_in) && load_mask_out != 8'h00);
    cov_hw_reset: cover property ((!hw_reset_n_in)[*5]);
    cov_frame: cover property ($rose(frame_sel_n_in) && !load_strobe_n_in);
endmodule
bind odu_top odu_top_properties i_odu_top_properties (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .frame_sel_n_in(frame_sel_n_in), .load_strobe_n_in(load_strobe_n_in), .hw_reset_n_in(hw_reset_n_in),
    .power_up_level_select_in(power_up_level_select_in), .has_level_select_in(has_level_select_in),
    .dac_code_out(dac_code_out), .input_code_out(input_code_out), .load_mask_out(load_mask_out),
    .gain_two_out(gain_two_out), .reference_off_out(reference_off_out), .por_busy_out(por_busy_out));

// *** test/tb_odu_top.sv ***
// Self-checking bench for the converter update, reset and setup control.
`timescale 1ns/1ns
module tb_odu_top
    import odu_pkg::*;
;
    localparam logic [NUM_CHANNELS*CODE_WIDTH-1:0] ALL_MID = {NUM_CHANNELS{CODE_MID}};
    logic                                    mclk = 1'b0, resetn = 1'b0, ld_n = 1'b1, hw_n = 1'b1;
    logic                                    sel = 1'b1, has = 1'b1, sclk, sdi, fs_n, gain, refoff, busy;
    logic [NUM_CHANNELS-1:0][CODE_WIDTH-1:0] dac, inp;
    logic [NUM_CHANNELS-1:0]                 mask;
    int                                      fails = 0, tests_run = 0;
    initial forever #5 mclk = ~mclk;
    odu_host_model i_odu_host_model (.clk_in(mclk), .sclk_out(sclk), .sdi_out(sdi), .frame_sel_n_out(fs_n));
    odu_top i_odu_top (.mclk_in(mclk), .resetn_in(resetn), .sclk_in(sclk), .sdi_in(sdi), .frame_sel_n_in(fs_n),
        .load_strobe_n_in(ld_n), .hw_reset_n_in(hw_n), .power_up_level_select_in(sel), .has_level_select_in(has),
        .dac_code_out(dac), .input_code_out(inp), .load_mask_out(mask), .gain_two_out(gain),
        .reference_off_out(refoff), .por_busy_out(busy));
    task automatic chk(input logic [NUM_CHANNELS*CODE_WIDTH-1:0] seen, input logic [NUM_CHANNELS*CODE_WIDTH-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic send(input logic [3:0] cmd, input logic [3:0] addr, input logic [CODE_WIDTH-1:0] data);
        i_odu_host_model.send({cmd, addr, data});
        repeat (12) @(posedge mclk);
    endtask
    task automatic do_reset(input logic h, input logic s);
        int n;
        resetn <= 1'b0;
        has <= h;
        sel <= s;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        n = 0;
        @(posedge mclk);
        while (busy !== 1'b0 && n < 50) begin
            @(posedge mclk);
            n++;
        end
        if (n == 50) begin
            fails++;
            end_sim();
        end
        repeat (4) @(posedge mclk);
    endtask
    task automatic t_power_up();
        chk(dac, ALL_MID);
        chk(mask, 8'h00);
        chk(gain, 1'b0);
        chk(refoff, 1'b0);
    endtask
    task automatic t_deferred();
        send(CMD_WRITE_INPUT, 4'h0, 16'h1111);
        send(CMD_WRITE_INPUT, 4'h1, 16'h2222);
        chk(inp[1], 16'h2222);
        chk(dac[0], CODE_MID);
        send(CMD_LOAD_MASK, 4'hf, 16'h0002);
        chk(mask, 8'h02);
        ld_n <= 1'b0;
        repeat (8) @(posedge mclk);
        chk(dac[0], 16'h1111);
        chk(dac[1], CODE_MID);
        ld_n <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask
    task automatic t_commands();
        send(CMD_UPDATE_DAC, 4'h0, 16'h0002);
        chk(dac[1], 16'h2222);
        chk(inp[0], 16'h1111);
        send(CMD_WRITE_UPDATE, 4'h2, 16'h3333);
        chk({dac[2], inp[2]}, 32'h33333333);
        send(CMD_SETUP, 4'ha, 16'hfff5);
        chk(gain, 1'b1);
        chk(refoff, 1'b1);
    endtask
    task automatic t_immediate();
        ld_n <= 1'b0;
        repeat (8) @(posedge mclk);
        send(CMD_WRITE_INPUT, 4'h1, 16'h4444);
        chk(dac[1], 16'h4444);
        send(CMD_WRITE_INPUT, 4'h3, 16'h5555);
        chk(dac[3], 16'h5555);
        ld_n <= 1'b1;
    endtask
    task automatic t_resets();
        hw_n <= 1'b0;
        repeat (8) @(posedge mclk);
        chk(dac, ALL_MID);
        send(CMD_WRITE_UPDATE, 4'h4, 16'h6666);
        chk(dac[4], CODE_MID);
        hw_n <= 1'b1;
        repeat (20) @(posedge mclk);
        chk(dac, ALL_MID);
        send(CMD_LOAD_MASK, 4'h0, 16'h00a5);
        send(CMD_WRITE_UPDATE, 4'h5, 16'h7777);
        send(CMD_SOFT_RESET, 4'h0, 16'h0000);
        chk(dac, ALL_MID);
        chk({mask, gain, refoff}, 10'h000);
        do_reset(1'b0, 1'b1);
        chk(dac, '0);
        do_reset(1'b1, 1'b0);
        chk(dac, '0);
    endtask
    initial begin
        do_reset(1'b1, 1'b1);
        t_power_up();
        t_deferred();
        t_commands();
        t_immediate();
        t_resets();
        end_sim();
    end
endmodule
